// ===== hdl/pemux_port_e.sv
// Purpose: port E pin mux with data, direction, assignment and pull-up registers
// Assumes: mode and bus-control sources are on clk_i; pins are asynchronous
// Notes: absent registers read zero and drop writes but still acknowledge
`timescale 1ns/1ps
`default_nettype none

module pemux_port_e #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // operating mode and mode register bits from the mode logic, and the mode register write back to it
  input wire logic [2:0] mode_i,
  input wire logic emulate_port_e_i,
  input wire logic internal_visibility_i,
  input wire logic e_clock_stretch_i,
  output logic mode_wr_o,
  output logic [7:0] mode_wdata_o,
  // internal bus control sources
  input wire logic bus_e_clock_i,
  input wire logic queue_status_hi_i,
  input wire logic queue_status_lo_i,
  input wire logic low_byte_strobe_i,
  input wire logic rw_pin_i,
  input wire logic pll_test_i,
  // port e pins
  input wire logic [7:0] pe_pin_i,
  output logic [7:0] pe_pin_o,
  output logic [7:0] pe_pin_oe_o,
  output logic [7:0] pe_pullup_o,
  // derived inputs and the pull-up control register
  output logic aux_reset_in_o,
  output logic nonmaskable_int_in_o,
  output logic maskable_int_in_n_o,
  output logic bus_e_clock_in_o,
  output logic [7:0] pullup_ctrl_reg_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [7:0] pin_data_reg_e;
    logic [7:0] pin_direction_reg_e;
    logic [7:0] function_assign_reg;
    logic assign_written;
    logic [7:0] pullup_ctrl_reg;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic mode_wr;
    logic [7:0] mode_wdata;
  } pemux_state_t;

  pemux_state_t st_q;
  pemux_state_t st_d;

  // ****************************************
  // mode decode
  // ****************************************
  logic is_special;
  logic is_single;
  logic is_periph;
  logic is_normal_narrow;
  logic is_normal_exp;
  logic is_expanded;
  assign is_special = ~mode_i[2];
  assign is_single = (mode_i == pemux_pkg::MODE_SPECIAL_SINGLE)
                   | (mode_i == pemux_pkg::MODE_NORMAL_SINGLE);
  assign is_periph = (mode_i == pemux_pkg::MODE_SPECIAL_PERIPH)
                   | (mode_i == pemux_pkg::MODE_FORCED_PERIPH);
  assign is_normal_narrow = (mode_i == pemux_pkg::MODE_NORMAL_NARROW);
  assign is_normal_exp = is_normal_narrow | (mode_i == pemux_pkg::MODE_NORMAL_WIDE);
  assign is_expanded = ~is_single & ~is_periph;

  // ****************************************
  // function selection
  // ****************************************
  logic [7:0] far;
  logic sel_aux_reset;
  logic sel_pipe;
  logic sel_pll;
  logic sel_bus_e_clock;
  logic sel_low_byte_strobe;
  logic sel_rw;
  assign far = st_q.function_assign_reg;
  assign sel_aux_reset = far[pemux_pkg::AUX_RESET_ENABLE_BIT];
  assign sel_pipe = far[pemux_pkg::PIPE_STATUS_ENABLE_BIT] & ~is_single;
  // pipe status takes priority over the pll test output
  assign sel_pll = far[pemux_pkg::PLL_TEST_OUT_ENABLE_BIT] & ~is_single
                 & ~is_normal_exp & ~sel_pipe;
  assign sel_bus_e_clock = ~far[pemux_pkg::NO_EXT_ECLOCK_BIT]
                  & (~is_single | internal_visibility_i | ~e_clock_stretch_i);
  assign sel_low_byte_strobe = far[pemux_pkg::LOW_STROBE_ENABLE_BIT] & ~is_single
                   & ~is_normal_narrow;
  assign sel_rw = far[pemux_pkg::RW_PIN_ENABLE_BIT] & ~is_single;

  // ****************************************
  // pin drive
  // ****************************************
  always_comb
  begin
    // general-purpose default, direction bit decides
    pe_pin_o = st_q.pin_data_reg_e;
    pe_pin_oe_o = st_q.pin_direction_reg_e & pemux_pkg::WRITABLE_MASK;
    if (sel_aux_reset)
    begin
      pe_pin_oe_o[7] = 1'b0;
    end
    if (sel_pipe)
    begin
      pe_pin_o[6] = queue_status_hi_i;
      pe_pin_o[5] = queue_status_lo_i;
      pe_pin_oe_o[6] = 1'b1;
      pe_pin_oe_o[5] = 1'b1;
    end
    else if (sel_pll)
    begin
      pe_pin_o[6] = pll_test_i;
      pe_pin_oe_o[6] = 1'b1;
    end
    if (sel_bus_e_clock)
    begin
      // peripheral mode receives e clock from the external master
      pe_pin_o[4] = bus_e_clock_i;
      pe_pin_oe_o[4] = ~is_periph;
    end
    if (sel_low_byte_strobe)
    begin
      pe_pin_o[3] = low_byte_strobe_i;
      pe_pin_oe_o[3] = 1'b1;
    end
    if (sel_rw)
    begin
      pe_pin_o[2] = rw_pin_i;
      pe_pin_oe_o[2] = 1'b1;
    end
    pe_pin_oe_o[1:0] = 2'b00;
  end

  // pull-ups only on input pins; irq input always pulled
  logic pup_e;
  assign pup_e = st_q.pullup_ctrl_reg[pemux_pkg::PULLUP_ENABLE_E_BIT];
  always_comb
  begin
    pe_pullup_o = pemux_pkg::ZERO_BYTE;
    pe_pullup_o[3] = pup_e & ~pe_pin_oe_o[3];
    pe_pullup_o[2] = pup_e & ~pe_pin_oe_o[2];
    pe_pullup_o[1] = 1'b1;
    pe_pullup_o[0] = pup_e;
  end

  // reset timing is applied by the reset controller, as for the reset pin
  assign aux_reset_in_o = sel_aux_reset & st_q.pin_sync[7];
  assign nonmaskable_int_in_o = st_q.pin_sync[0];
  assign maskable_int_in_n_o = st_q.pin_sync[1];
  assign bus_e_clock_in_o = st_q.pin_sync[4];
  assign pullup_ctrl_reg_o = st_q.pullup_ctrl_reg;
  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = {24'h000000, st_q.rdata};
  assign mode_wr_o = st_q.mode_wr;
  assign mode_wdata_o = st_q.mode_wdata;

  // ****************************************
  // register access
  // ****************************************
  logic req;
  logic [5:0] idx;
  logic port_mapped;
  logic assign_mapped;
  logic pullup_mapped;
  logic wr_lane;
  logic [7:0] wdata;
  logic [7:0] pin_view;
  assign req = wb_cyc_i & wb_stb_i & ~st_q.ack;
  assign idx = wb_adr_i[7:2];
  assign port_mapped = ~is_periph & ~(is_expanded & emulate_port_e_i);
  assign assign_mapped = ~is_periph;
  assign pullup_mapped = ~is_periph;
  assign wr_lane = wb_we_i & wb_sel_i[0];
  assign wdata = wb_dat_i[7:0];
  // outputs read back the latch, inputs the synchronised pin
  assign pin_view = (st_q.pin_data_reg_e & pe_pin_oe_o) | (st_q.pin_sync & ~pe_pin_oe_o);

  logic [7:0] far_wmask;
  always_comb
  begin
    far_wmask = pemux_pkg::ZERO_BYTE;
    far_wmask[pemux_pkg::AUX_RESET_ENABLE_BIT] = 1'b1;
    // one shared first-write flag for the protected bits
    far_wmask[pemux_pkg::PLL_TEST_OUT_ENABLE_BIT] = is_special & st_q.assign_written;
    far_wmask[pemux_pkg::PIPE_STATUS_ENABLE_BIT] =
      is_special ? st_q.assign_written : ~st_q.assign_written;
    far_wmask[pemux_pkg::LOW_STROBE_ENABLE_BIT] =
      far_wmask[pemux_pkg::PIPE_STATUS_ENABLE_BIT];
    far_wmask[pemux_pkg::RW_PIN_ENABLE_BIT] = far_wmask[pemux_pkg::PIPE_STATUS_ENABLE_BIT];
    far_wmask[pemux_pkg::NO_EXT_ECLOCK_BIT] = ~is_special;
  end

  always_comb
  begin
    st_d = st_q;
    st_d.pin_meta = pe_pin_i;
    st_d.pin_sync = st_q.pin_meta;
    st_d.ack = req;
    st_d.mode_wr = 1'b0;
    if (req)
    begin
      st_d.rdata = pemux_pkg::ZERO_BYTE;
      unique case (idx)
        pemux_pkg::IDX_PIN_DATA:
          if (port_mapped)
          begin
            st_d.rdata = pin_view;
            if (wr_lane)
            begin
              st_d.pin_data_reg_e = wdata;
            end
          end
        pemux_pkg::IDX_PIN_DIR:
          if (port_mapped)
          begin
            st_d.rdata = st_q.pin_direction_reg_e & pemux_pkg::WRITABLE_MASK;
            if (wr_lane)
            begin
              st_d.pin_direction_reg_e = wdata & pemux_pkg::WRITABLE_MASK;
            end
          end
        pemux_pkg::IDX_FUNC_ASSIGN:
          if (assign_mapped)
          begin
            st_d.rdata = far & pemux_pkg::WRITABLE_MASK;
            if (wr_lane)
            begin
              st_d.function_assign_reg = ((far & ~far_wmask) | (wdata & far_wmask))
                                       & pemux_pkg::WRITABLE_MASK;
              st_d.assign_written = 1'b1;
            end
            // mode byte rides in the next lane so both change on one edge
            if (wb_we_i & wb_sel_i[1])
            begin
              st_d.mode_wr = 1'b1;
              st_d.mode_wdata = wb_dat_i[pemux_pkg::MODE_LANE_LO +: 8];
            end
          end
        pemux_pkg::IDX_PULLUP_CTRL:
          if (pullup_mapped)
          begin
            st_d.rdata = st_q.pullup_ctrl_reg;
            if (wr_lane)
            begin
              st_d.pullup_ctrl_reg = wdata;
            end
          end
        default:
          st_d.rdata = pemux_pkg::ZERO_BYTE;
      endcase
    end
    if (rst_i)
    begin
      st_d = '0;
      st_d.function_assign_reg = pemux_pkg::pemux_assign_reset(mode_i);
      st_d.pullup_ctrl_reg = pemux_pkg::PULLUP_RESET;
      if (is_normal_narrow)
      begin
        // keeps the strobe pin high through and after reset
        st_d.pin_data_reg_e = pemux_pkg::NARROW_PIN3_RESET;
        st_d.pin_direction_reg_e = pemux_pkg::NARROW_PIN3_RESET;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    st_q <= st_d;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_assign_write;
    req && wb_we_i && wb_sel_i[0] && idx == pemux_pkg::IDX_FUNC_ASSIGN && assign_mapped;
  endsequence

  sequence s_port_read_hidden;
    req && idx == pemux_pkg::IDX_PIN_DATA && !port_mapped;
  endsequence

  property p_bus_e_clock_owns_pin;
    sel_bus_e_clock && !is_periph |-> pe_pin_oe_o[4] && pe_pin_o[4] == bus_e_clock_i;
  endproperty
  a_bus_e_clock_owns_pin: assert property (p_bus_e_clock_owns_pin)
    else $error("e clock does not own pin 4");

  property p_gpio_dir;
    !sel_rw |-> pe_pin_oe_o[2] == st_q.pin_direction_reg_e[2];
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("pin 2 drive differs from direction bit");

  property p_int_pins_in;
    pe_pin_oe_o[1:0] == 2'b00;
  endproperty
  a_int_pins_in: assert property (p_int_pins_in)
    else $error("interrupt pin driven");

  property p_pipe_wins;
    sel_pipe |-> pe_pin_o[6] == queue_status_hi_i && pe_pin_o[5] == queue_status_lo_i;
  endproperty
  a_pipe_wins: assert property (p_pipe_wins)
    else $error("pipe status not on pins 6 and 5");

  property p_pll_normal_locked;
    s_assign_write ##0 !is_special |=> $stable(far[pemux_pkg::PLL_TEST_OUT_ENABLE_BIT]);
  endproperty
  a_pll_normal_locked: assert property (p_pll_normal_locked)
    else $error("pll test bit changed in normal mode");

  property p_once_protect;
    s_assign_write ##0 !is_special && st_q.assign_written
      |=> $stable(far[pemux_pkg::PIPE_STATUS_ENABLE_BIT]);
  endproperty
  a_once_protect: assert property (p_once_protect)
    else $error("pipe enable written twice in normal mode");

  property p_noclk_special;
    s_assign_write ##0 is_special |=> $stable(far[pemux_pkg::NO_EXT_ECLOCK_BIT]);
  endproperty
  a_noclk_special: assert property (p_noclk_special)
    else $error("no-clock bit written in special mode");

  property p_narrow_reset;
    $past(rst_i) && is_normal_narrow |-> pe_pin_oe_o[3] && pe_pin_o[3];
  endproperty
  a_narrow_reset: assert property (p_narrow_reset)
    else $error("pin 3 not driving high after reset");

  property p_hidden_read;
    s_port_read_hidden |=> wb_ack_o && wb_dat_o == 32'h00000000;
  endproperty
  a_hidden_read: assert property (p_hidden_read)
    else $error("hidden port register returned data");

  property p_pullup_inputs;
    pe_pullup_o[3] |-> pup_e && !pe_pin_oe_o[3];
  endproperty
  a_pullup_inputs: assert property (p_pullup_inputs)
    else $error("pull-up on driven pin 3");

  property p_aux_pin_in;
    sel_aux_reset |-> !pe_pin_oe_o[pemux_pkg::AUX_RESET_ENABLE_BIT];
  endproperty
  a_aux_pin_in: assert property (p_aux_pin_in)
    else $error("aux reset pin driven");

  property p_ack_one;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack not a single cycle");

endmodule : pemux_port_e

`default_nettype wire

// ===== include/pemux_pkg.sv
// Purpose: constants, register map and reset values for the port E function mux
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes: register index times four gives the byte address

package pemux_pkg;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [5:0] IDX_PIN_DATA = 6'h08;
  localparam logic [5:0] IDX_PIN_DIR = 6'h09;
  localparam logic [5:0] IDX_FUNC_ASSIGN = 6'h0a;
  localparam logic [5:0] IDX_PULLUP_CTRL = 6'h0c;

  // ****************************************
  // fields and masks
  // ****************************************
  localparam int AUX_RESET_ENABLE_BIT = 7;
  localparam int PLL_TEST_OUT_ENABLE_BIT = 6;
  localparam int PIPE_STATUS_ENABLE_BIT = 5;
  localparam int NO_EXT_ECLOCK_BIT = 4;
  localparam int LOW_STROBE_ENABLE_BIT = 3;
  localparam int RW_PIN_ENABLE_BIT = 2;
  localparam int PULLUP_ENABLE_H_BIT = 7;
  localparam int PULLUP_ENABLE_G_BIT = 6;
  localparam int PULLUP_ENABLE_E_BIT = 4;
  localparam int MODE_LANE_LO = 8;
  localparam logic [7:0] WRITABLE_MASK = 8'hfc;
  localparam logic [7:0] PULLUP_RESET = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] NARROW_PIN3_RESET = 8'h08;

  // ****************************************
  // operating modes, {bkgd, mode b, mode a}
  // ****************************************
  localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
  localparam logic [2:0] MODE_SPECIAL_NARROW = 3'h1;
  localparam logic [2:0] MODE_SPECIAL_PERIPH = 3'h2;
  localparam logic [2:0] MODE_SPECIAL_WIDE = 3'h3;
  localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
  localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
  localparam logic [2:0] MODE_FORCED_PERIPH = 3'h6;
  localparam logic [2:0] MODE_NORMAL_WIDE = 3'h7;

  localparam logic [7:0] ASSIGN_RESET_SPECIAL = 8'h2c;
  localparam logic [7:0] ASSIGN_RESET_PERIPH = 8'h50;
  localparam logic [7:0] ASSIGN_RESET_NORMAL_SINGLE = 8'h10;
  localparam logic [7:0] ASSIGN_RESET_NORMAL_EXP = 8'h00;

  // reset value of the assignment register for a mode
  function automatic logic [7:0] pemux_assign_reset(input logic [2:0] mode);
    logic [7:0] val;
    val = ASSIGN_RESET_NORMAL_EXP;
    unique case (mode)
      MODE_SPECIAL_SINGLE, MODE_SPECIAL_NARROW, MODE_SPECIAL_WIDE:
        val = ASSIGN_RESET_SPECIAL;
      MODE_SPECIAL_PERIPH, MODE_FORCED_PERIPH:
        val = ASSIGN_RESET_PERIPH;
      MODE_NORMAL_SINGLE:
        val = ASSIGN_RESET_NORMAL_SINGLE;
      MODE_NORMAL_NARROW, MODE_NORMAL_WIDE:
        val = ASSIGN_RESET_NORMAL_EXP;
    endcase
    return val;
  endfunction : pemux_assign_reset

endpackage : pemux_pkg

// ===== bench/pemux_pin_model.sv
// Purpose: far-side model of the port E pins and the parts hung on them
// Assumes: design drive wins, then external drive, then the pull-up
// Notes: an undriven pin without pull-up toggles every cycle
`timescale 1ns/1ps
`default_nettype none

module pemux_pin_model (
  input wire logic clk_i,
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pullup_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pin_i_o
);
  // ****************************************
  // wire resolution
  // ****************************************
  logic [7:0] last_q = 8'h00;

  always_ff @(posedge clk_i)
  begin
    last_q <= pin_i_o;
  end

  // floating pins never hold a stale level, so a missed drive shows up
  assign pin_i_o = (oe_i & pin_o_i) | (~oe_i & ext_en_i & ext_val_i)
    | (~oe_i & ~ext_en_i & (pullup_i | ~last_q));

endmodule : pemux_pin_model

`default_nettype wire

// ===== bench/testbench.sv
// Purpose: self-checking bench for the port E function mux
// Assumes: classic wishbone, ack one cycle after the request is taken
// Notes: each mode is entered through a fresh reset
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ****************************************
  // stimulus and plumbing
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [2:0] mode = 3'h4;
  logic emul = 1'b0;
  logic internal_visibility = 1'b0;
  logic e_clock_stretch = 1'b1;
  logic [5:0] src = 6'h1a;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic [31:0] rdat;
  logic mwr;
  logic [7:0] mdat;
  logic [31:0] wdo;
  logic ack;
  logic mwo;
  logic [7:0] mdo;
  logic [7:0] po;
  logic [7:0] poe;
  logic [7:0] ppu;
  logic [7:0] pin;
  logic aux;
  logic [7:0] puc;
  logic nmi;
  logic irqn;
  logic eci;
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] ea [8] = '{8'h2c, 8'h2c, 8'h00, 8'h2c, 8'h10, 8'h00, 8'h00, 8'h00};

  always #20 clk_i = ~clk_i;

  pemux_port_e dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo),
    .wb_ack_o(ack), .mode_i(mode), .emulate_port_e_i(emul),
    .internal_visibility_i(internal_visibility), .e_clock_stretch_i(e_clock_stretch), .mode_wr_o(mwo),
    .mode_wdata_o(mdo), .bus_e_clock_i(src[2]), .queue_status_hi_i(src[4]),
    .queue_status_lo_i(src[3]), .low_byte_strobe_i(src[1]), .rw_pin_i(src[0]),
    .pll_test_i(src[5]), .pe_pin_i(pin), .pe_pin_o(po), .pe_pin_oe_o(poe),
    .pe_pullup_o(ppu), .aux_reset_in_o(aux), .nonmaskable_int_in_o(nmi),
    .maskable_int_in_n_o(irqn), .bus_e_clock_in_o(eci), .pullup_ctrl_reg_o(puc));

  pemux_pin_model pins_u (.clk_i(clk_i), .pin_o_i(po), .oe_i(poe), .pullup_i(ppu),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_i_o(pin));

  task final_report;
    $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      bad_count++;
      $display("[ERR] %0t no acknowledge", $time);
      final_report();
    end
    rdat = wdo;
    mwr = mwo;
    mdat = mdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, {24'h0, d}, 4'h1);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(rdat[7:0], e);
  endtask : rc

  task automatic rst(input logic [2:0] m);
    @(posedge clk_i);
    rst_i <= 1'b1;
    mode <= m;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : rst

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    for (int m = 0; m < 8; m++)
    begin
      rst(3'(m));
      @(posedge clk_i);
      rc(8'h28, ea[m]);
      rc(8'h30, (m == 2 || m == 6) ? 8'h00 : 8'hff);
      rc(8'h24, (m == 5) ? 8'h08 : 8'h00);
      if (m == 5)
        chk(poe & po & 8'h08, 8'h08);
      if (m == 2)
        chk(poe & 8'h50, 8'h40);
    end
    // normal single chip: plain i/o, pins, pull-ups
    rst(3'h4);
    wr(8'h24, 8'hff);
    rc(8'h24, 8'hfc);
    wr(8'h20, 8'ha4);
    chk(poe, 8'hfc);
    chk(po & 8'hfc, 8'ha4);
    wr(8'h24, 8'h00);
    ext_val <= 8'h4a;
    ext_en <= 8'hff;
    repeat (3) @(posedge clk_i);
    rc(8'h20, 8'h4a);
    chk({5'h0, eci, irqn, nmi}, 8'h02);
    ext_en <= 8'h00;
    wr(8'h28, 8'h13);
    rc(8'h28, 8'h10);
    rc(8'h3c, 8'h00);
    wr(8'h30, 8'h2f);
    chk(puc, 8'h2f);
    chk(ppu & 8'h0f, 8'h02);
    wr(8'h30, 8'hff);
    chk(ppu, 8'h0f);
    wr(8'h24, 8'h08);
    chk(ppu, 8'h07);
    // normal wide: write-once bits and alternate functions
    rst(3'h7);
    @(posedge clk_i);
    chk(poe, 8'h10);
    wr(8'h28, 8'h2c);
    chk(poe, 8'h7c);
    chk(po & 8'h7c, 8'h68);
    wr(8'h28, 8'h40);
    rc(8'h28, 8'h2c);
    wr(8'h28, 8'h50);
    rc(8'h28, 8'h3c);
    wr(8'h28, 8'hbc);
    ext_val <= 8'h80;
    ext_en <= 8'h80;
    repeat (4) @(posedge clk_i);
    chk({7'h0, aux}, 8'h01);
    wb(1'b1, 8'h28, 32'h0000a5bc, 4'h3);
    chk({mdat[7:0]}, 8'ha5);
    chk({7'h0, mwr}, 8'h01);
    ext_en <= 8'h00;
    emul <= 1'b1;
    wr(8'h20, 8'hff);
    rc(8'h20, 8'h00);
    emul <= 1'b0;
    // special wide: all but the first write, pll versus pipe
    rst(3'h3);
    // pll high, queue hi low: pin 6 tells the two sources apart
    src <= 6'h2d;
    wr(8'h28, 8'h00);
    rc(8'h28, 8'h2c);
    wr(8'h28, 8'h40);
    rc(8'h28, 8'h40);
    chk(poe & 8'h50, 8'h50);
    chk(po & 8'h40, 8'h40);
    wr(8'h28, 8'h70);
    rc(8'h28, 8'h60);
    chk(po & 8'h60, 8'h20);
    // special single chip: e clock only with visibility or no stretch
    rst(3'h0);
    @(posedge clk_i);
    chk(poe, 8'h00);
    internal_visibility <= 1'b1;
    @(posedge clk_i);
    chk(poe & po, 8'h10);
    internal_visibility <= 1'b0;
    e_clock_stretch <= 1'b0;
    @(posedge clk_i);
    chk(poe & po, 8'h10);
    final_report();
  end

endmodule : testbench

`default_nettype wire
